/* design/twp_defines.svh */
// Constants of the texture writeback packer: register offsets, field positions,
// reset values and fixed message figures.
// Assumes inclusion by bare name from every design file that needs them.
`ifndef TWP_DEFINES_SVH
`define TWP_DEFINES_SVH

`define TWP_CTRL_OFS        8'h00
`define TWP_STATUS_OFS      8'h04
`define TWP_MSGCNT_OFS      8'h08

`define TWP_CTRL_EN_BIT     0
`define TWP_CTRL_NPOL_BIT   1
`define TWP_CTRL_EN_RST     1'h1
`define TWP_CTRL_NPOL_RST   1'h0
`define TWP_STATUS_BUSY_BIT 0

`define TWP_CHANNELS        4
`define TWP_LANES16         16
`define TWP_LANES8          8
`define TWP_EXTRA_SLOT      3'h4
`define TWP_FIFO_DEPTH      4
`define TWP_MASK_DW0_EN     16'h0003
`define TWP_ONES16          16'hffff
`define TWP_ONES8           8'hff

`endif

/* design/twp_pkg.sv */
// Types shared by the texture writeback packer and its output queue.
// Assumes twp_defines.svh carries the numeric constants.
package twp_pkg;

  typedef enum logic {
    TWP_SIMD16_H16 = 1'b0,
    TWP_SIMD8_F32  = 1'b1
  } twp_mode_t;

  typedef enum logic [1:0] {
    TWP_FMT_FLOAT = 2'b00,
    TWP_FMT_SINT  = 2'b01,
    TWP_FMT_UINT  = 2'b10
  } twp_fmt_t;

  typedef enum logic {
    TWP_IDLE = 1'b0,
    TWP_EMIT = 1'b1
  } twp_fsm_t;

  typedef struct packed {
    twp_mode_t     mode;
    twp_fmt_t      fmt;
    logic [3:0]    chan_skip;
    logic [15:0]   exec;
    logic          null_en;
    logic          fault_en;
    logic          killpix;
    logic [15:0]   border;
    logic [15:0]   nullhit;
    logic [7:0]    kill;
    logic [2047:0] texel;
  } twp_req_t;

  typedef struct packed {
    logic [255:0] data;
    logic [15:0]  hw_en;
    logic [2:0]   reg_idx;
    logic         last;
  } twp_wb_t;

endpackage : twp_pkg

/* design/twp_fifo_if.sv */
// Valid/ready carrier between the packer and its output queue.
// Assumes both ends share pclk.
`timescale 1ns/1ps
interface twp_fifo_if #(parameter int W = 8);
  logic         in_valid;
  logic         in_ready;
  logic [W-1:0] in_data;
  logic         out_valid;
  logic         out_ready;
  logic [W-1:0] out_data;
  modport fifo (input in_valid, input in_data, input out_ready,
                output in_ready, output out_valid, output out_data);
  modport user (output in_valid, output in_data, output out_ready,
                input in_ready, input out_valid, input out_data);
endinterface : twp_fifo_if

/* design/twp_fifo.sv */
// Small queue with a registered output word; width and depth are parameters.
// Assumes one clock and an asynchronous active-low reset; D is a power of two.
`timescale 1ns/1ps
module twp_fifo #(
  parameter int W = 8,
  parameter int D = 4
) (
  input wire logic pclk,
  input wire logic presetn,
  twp_fifo_if.fifo f
);
  localparam int AW = $clog2(D);
  localparam int CW = $clog2(D + 1);

  typedef struct packed {
    logic [D-1:0][W-1:0] mem;
    logic [AW-1:0]       wp;
    logic [AW-1:0]       rp;
    logic [CW-1:0]       cnt;
    logic                ov;
    logic [W-1:0]        od;
  } twp_fifo_state_t;

  twp_fifo_state_t s;
  twp_fifo_state_t next_s;
  logic            push;
  logic            load;

  // The output register is outside the count, so full means D words waiting.
  assign f.in_ready  = (s.cnt != CW'(D));
  assign f.out_valid = s.ov;
  assign f.out_data  = s.od;

  always_comb begin
    next_s = s;
    push   = f.in_valid & (s.cnt != CW'(D));
    load   = (~s.ov | f.out_ready) & (s.cnt != '0);
    if (s.ov & f.out_ready) begin
      next_s.ov = 1'b0;
    end
    if (load) begin
      next_s.od = s.mem[s.rp];
      next_s.ov = 1'b1;
      next_s.rp = s.rp + AW'(1);
    end
    if (push) begin
      next_s.mem[s.wp] = f.in_data;
      next_s.wp        = s.wp + AW'(1);
    end
    next_s.cnt = s.cnt + CW'(push) - CW'(load);
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s <= '0;
    end else begin
      s <= next_s;
    end
  end
endmodule : twp_fifo

/* design/twp_packer.sv */
// Texture writeback packer: turns one sampler result into one writeback message,
// one destination register per output word, through a four-word queue.
// Assumes requests and the register bus come from logic on pclk; APB3 slave.
//
// Decided for this implementation: the register addresses and register access over APB.
`timescale 1ns/1ps
`include "twp_defines.svh"
module twp_packer (
  input  wire logic                pclk,
  input  wire logic                presetn,
  input  wire logic                psel,
  input  wire logic                penable,
  input  wire logic                pwrite,
  input  wire logic [7:0]          paddr,
  input  wire logic [31:0]         pwdata,
  output logic      [31:0]         prdata,
  output logic                     pready,
  output logic                     pslverr,
  input  wire logic                req_valid,
  output logic                     req_ready,
  input  wire twp_pkg::twp_req_t   req,
  output logic                     wb_valid,
  input  wire logic                wb_ready,
  output logic      [255:0]        wb_data,
  output logic      [15:0]         wb_hw_en,
  output logic      [2:0]          wb_reg,
  output logic                     wb_last
);

  typedef struct packed {
    twp_pkg::twp_fsm_t fsm;
    twp_pkg::twp_req_t req;
    logic [2:0]        slot;
    logic [2:0]        ridx;
    logic              rdy;
    logic              en;
    logic              npol;
    logic [31:0]       msgs;
    logic [31:0]       prdata;
    logic              pready;
    logic              pslverr;
  } twp_state_t;

  twp_state_t      s;
  twp_state_t      next_s;
  twp_pkg::twp_wb_t w;
  logic            have;
  logic            later;
  logic            extra;
  logic            advance;
  logic [31:0]     v;
  logic [7:0]      low8;

  twp_fifo_if #(.W($bits(twp_pkg::twp_wb_t))) wbq ();

  twp_fifo #(
    .W ($bits(twp_pkg::twp_wb_t)),
    .D (`TWP_FIFO_DEPTH)
  ) u_queue (
    .pclk    (pclk),
    .presetn (presetn),
    .f       (wbq.fifo)
  );

  twp_pkg::twp_wb_t qout;

  assign wbq.in_valid  = have & (s.fsm == twp_pkg::TWP_EMIT);
  assign wbq.in_data   = w;
  assign wbq.out_ready = wb_ready;
  assign qout          = wbq.out_data;

  // All outputs come from flip-flops: bus answers from the state, the
  // writeback word from the queue's output register.
  assign prdata    = s.prdata;
  assign pready    = s.pready;
  assign pslverr   = s.pslverr;
  assign req_ready = s.rdy;
  assign wb_valid  = wbq.out_valid;
  assign wb_data   = qout.data;
  assign wb_hw_en  = qout.hw_en;
  assign wb_reg    = qout.reg_idx;
  assign wb_last   = qout.last;

  // Converts a 32-bit result to the 16-bit return encoding. Floats are
  // truncated and small values flush to zero, which trades exact rounding
  // for a short path.
  function automatic logic [15:0] twp_conv(input logic [31:0] x,
                                           input twp_pkg::twp_fmt_t f);
    logic [15:0] r;
    r = '0;
    case (f)
      twp_pkg::TWP_FMT_SINT: begin
        if (!x[31] && x[30:15] != '0) begin
          r = 16'h7fff;
        end else if (x[31] && x[30:15] != 16'hffff) begin
          r = 16'h8000;
        end else begin
          r = x[15:0];
        end
      end
      twp_pkg::TWP_FMT_UINT: begin
        r = (x[31:16] != '0) ? 16'hffff : x[15:0];
      end
      twp_pkg::TWP_FMT_FLOAT: begin
        if (x[30:23] == 8'hff) begin
          r = {x[31], 5'h1f, (x[22:0] != '0), 9'h000};
        end else if (x[30:23] > 8'h8e) begin
          r = {x[31], 5'h1f, 10'h000};
        end else if (x[30:23] < 8'h71) begin
          r = {x[31], 15'h0000};
        end else begin
          r = {x[31], 5'(x[30:23] - 8'h70), x[22:13]};
        end
      end
      default: begin
        r = x[15:0];
      end
    endcase
    return r;
  endfunction : twp_conv

  always_comb begin
    next_s  = s;
    w       = '0;
    v       = '0;
    low8    = '0;
    have    = 1'b0;
    later   = 1'b0;
    advance = 1'b0;

    // Register bus: answers are prepared in the setup cycle, so every
    // transfer completes in its first access cycle.
    next_s.pready  = psel & ~penable;
    next_s.pslverr = 1'b0;
    next_s.prdata  = '0;
    if (psel && !penable) begin
      case (paddr)
        `TWP_CTRL_OFS: begin
          next_s.prdata[`TWP_CTRL_EN_BIT]   = s.en;
          next_s.prdata[`TWP_CTRL_NPOL_BIT] = s.npol;
        end
        `TWP_STATUS_OFS: begin
          next_s.prdata[`TWP_STATUS_BUSY_BIT] = (s.fsm == twp_pkg::TWP_EMIT);
        end
        `TWP_MSGCNT_OFS: begin
          next_s.prdata = s.msgs;
        end
        default: begin
          next_s.pslverr = 1'b1;
        end
      endcase
    end
    if (psel && penable && s.pready && pwrite && paddr == `TWP_CTRL_OFS) begin
      next_s.en   = pwdata[`TWP_CTRL_EN_BIT];
      next_s.npol = pwdata[`TWP_CTRL_NPOL_BIT];
    end

    if (s.req.mode == twp_pkg::TWP_SIMD16_H16) begin
      extra = s.req.fault_en | s.req.null_en;
    end else begin
      extra = s.req.killpix | s.req.null_en;
    end

    for (int c = 0; c < `TWP_CHANNELS; c++) begin
      if (c > int'(s.slot) && !s.req.chan_skip[c]) begin
        later = 1'b1;
      end
    end

    w.reg_idx = s.ridx;
    if (s.slot < `TWP_EXTRA_SLOT) begin
      have   = ~s.req.chan_skip[s.slot[1:0]];
      w.last = ~later & ~extra;
      for (int p = 0; p < `TWP_LANES16; p++) begin
        v = s.req.texel[(int'(s.slot[1:0]) * `TWP_LANES16 + p) * 32 +: 32];
        if (s.req.null_en && s.npol && s.req.nullhit[p]) begin
          v = '0;
        end
        if (s.req.mode == twp_pkg::TWP_SIMD16_H16) begin
          // Halfword p is subspan p/4, pixel p%4, so the odd pixel lands high.
          w.data[p*16 +: 16] = twp_conv(v, s.req.fmt);
          w.hw_en[p]         = s.req.exec[p];
        end else if (p < `TWP_LANES8) begin
          w.data[p*32 +: 32]  = v;
          w.hw_en[p*2 +: 2]   = {2{s.req.exec[p]}};
        end
      end
    end else begin
      // A request with nothing to return still sends one empty last word.
      have   = extra | (s.ridx == '0);
      w.last = 1'b1;
      if (extra) begin
        w.hw_en = `TWP_MASK_DW0_EN;
        if (s.req.mode == twp_pkg::TWP_SIMD16_H16) begin
          w.data[31:16] = ~s.req.border;
          w.data[15:0]  = ~s.req.nullhit;
        end else if (s.req.killpix) begin
          low8 = s.req.null_en ? ~s.req.nullhit[7:0] : `TWP_ONES8;
          w.data[31:16] = `TWP_ONES16;
          w.data[15:0]  = {`TWP_ONES8, ~s.req.kill & low8};
        end else begin
          w.data[31:0] = {`TWP_ONES8, ~s.req.border[7:0],
                          `TWP_ONES8, ~s.req.nullhit[7:0]};
        end
      end
    end

    case (s.fsm)
      twp_pkg::TWP_IDLE: begin
        if (req_valid && s.rdy) begin
          next_s.req  = req;
          next_s.fsm  = twp_pkg::TWP_EMIT;
          next_s.slot = '0;
          next_s.ridx = '0;
        end
      end
      twp_pkg::TWP_EMIT: begin
        // A skipped slot costs one cycle; a filled one waits for queue room.
        advance = ~have | wbq.in_ready;
        if (advance) begin
          next_s.slot = s.slot + 3'h1;
          if (have) begin
            next_s.ridx = s.ridx + 3'h1;
          end
          if (s.slot == `TWP_EXTRA_SLOT) begin
            next_s.fsm  = twp_pkg::TWP_IDLE;
            next_s.msgs = s.msgs + 32'h1;
          end
        end
      end
      default: begin
        next_s.fsm = twp_pkg::TWP_IDLE;
      end
    endcase

    next_s.rdy = (next_s.fsm == twp_pkg::TWP_IDLE) & next_s.en;
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      s      <= '0;
      s.en   <= `TWP_CTRL_EN_RST;
      s.npol <= `TWP_CTRL_NPOL_RST;
      s.rdy  <= 1'b0;
    end else begin
      s <= next_s;
    end
  end
endmodule : twp_packer

/* dv/twp_packer_assertions.sv */
// Checker on the packer's ports: bus answer, busy window and word order.
// Assumes no request is taken while words of the last message are queued.
`timescale 1ns/1ps
module twp_packer_assertions (
  input wire logic              pclk,
  input wire logic              presetn,
  input wire logic              psel,
  input wire logic              penable,
  input wire logic [7:0]        paddr,
  input wire logic              pready,
  input wire logic              pslverr,
  input wire logic              req_valid,
  input wire logic              req_ready,
  input wire twp_pkg::twp_req_t req,
  input wire logic              wb_valid,
  input wire logic              wb_ready,
  input wire logic [255:0]      wb_data,
  input wire logic [15:0]       wb_hw_en,
  input wire logic [2:0]        wb_reg,
  input wire logic              wb_last
);
  logic [18:0] cap;
  logic [2:0]  nreg;
  wire         m16 = cap[18];
  wire         x16 = cap[17];
  wire         k8  = cap[16];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cap <= '0;
      nreg <= 3'h0;
    end else begin
      if (req_valid && req_ready)
        cap <= {req.mode == twp_pkg::TWP_SIMD16_H16, req.fault_en | req.null_en,
                req.killpix && req.mode == twp_pkg::TWP_SIMD8_F32, req.exec};
      if (wb_valid && wb_ready)
        nreg <= wb_last ? 3'h0 : nreg + 3'h1;
    end
  end
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_take; req_valid && req_ready; endsequence
  sequence s_busy; !req_ready [*5]; endsequence
  chk_apb_answer: assert property (psel && !penable |=> pready ##1 !pready)
    else $error("bus answer is not a single cycle");
  chk_apb_error: assert property (psel && !penable |=>
    pslverr == !($past(paddr) inside {8'h00, 8'h04, 8'h08}))
    else $error("error response does not match the address");
  chk_busy_window: assert property (s_take |=> s_busy)
    else $error("request port reopened early");
  chk_reg_order: assert property (wb_valid |-> wb_reg == nreg)
    else $error("register offsets are not consecutive");
  chk_reg_bound: assert property (wb_valid |-> wb_reg <= 3'h4 &&
    (wb_last || wb_reg <= 3'h3))
    else $error("too many registers in a message");
  chk_lane_enable: assert property (wb_valid && !wb_last && m16 |-> wb_hw_en == cap[15:0])
    else $error("lane enables differ from the execution mask");
  chk_mask_word: assert property (wb_valid && wb_last && m16 && x16 |->
    wb_hw_en == 16'h0003)
    else $error("mask register writes beyond dword 0");
  chk_kill_word: assert property (wb_valid && wb_last && k8 |->
    wb_data[31:8] == 24'hffffff && wb_hw_en == 16'h0003)
    else $error("discard register upper bits are not set");
  chk_word_hold: assert property (wb_valid && !wb_ready |=>
    wb_valid && $stable(wb_data) && $stable(wb_reg))
    else $error("word changed while stalled");
endmodule : twp_packer_assertions

bind twp_packer twp_packer_assertions chk (.pclk(pclk), .presetn(presetn), .psel(psel),
  .penable(penable), .paddr(paddr), .pready(pready), .pslverr(pslverr),
  .req_valid(req_valid), .req_ready(req_ready), .req(req), .wb_valid(wb_valid),
  .wb_ready(wb_ready), .wb_data(wb_data), .wb_hw_en(wb_hw_en), .wb_reg(wb_reg),
  .wb_last(wb_last));

/* dv/twp_sink.sv */
// Far-side model: the execution unit's register file taking writeback words.
// Assumes speed 0 takes every word, 1 one word in four cycles, 2 none.
`timescale 1ns/1ps
module twp_sink (
  input  wire logic       pclk,
  input  wire logic       presetn,
  input  wire logic [1:0] speed,
  output logic            wb_ready
);
  logic [1:0] cnt;
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) cnt <= 2'h0;
    else cnt <= cnt + 2'h1;
  end
  assign wb_ready = presetn && (speed == 2'h0 || (speed == 2'h1 && cnt == 2'h3));
endmodule : twp_sink

/* dv/texture_result_writeback_packer_test.sv */
// Bench for the packer: bus checks and one scenario per message shape.
// Assumes twp_sink as far side and the checker bound on its own.
`timescale 1ns/1ps
module texture_result_writeback_packer_test;
  logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata;
  logic pready, pslverr, req_valid = 1'b0, req_ready, wb_valid, wb_ready, wb_last;
  logic [255:0] wb_data;
  logic [15:0] wb_hw_en;
  logic [2:0] wb_reg;
  logic [1:0] speed = 2'h0;
  twp_pkg::twp_req_t req = '0;
  twp_pkg::twp_wb_t got[$], exp[$];
  int n_errors = 0, comparisons = 0, nmsg = 0;
  always #5 pclk = ~pclk;
  twp_packer dut (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .req_valid(req_valid), .req_ready(req_ready), .req(req),
    .wb_valid(wb_valid), .wb_ready(wb_ready), .wb_data(wb_data), .wb_hw_en(wb_hw_en),
    .wb_reg(wb_reg), .wb_last(wb_last));
  twp_sink far (.pclk(pclk), .presetn(presetn), .speed(speed), .wb_ready(wb_ready));
  always @(posedge pclk)
    if (wb_valid && wb_ready) got.push_back('{wb_data, wb_hw_en, wb_reg, wb_last});
  task automatic wrap_up();
    $display("errors %0d comparisons %0d", n_errors, comparisons);
    if (n_errors == 0 && comparisons > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask : wrap_up
  task automatic stuck();
    n_errors++;
    wrap_up();
  endtask : stuck
  task automatic chk(input logic [255:0] g, input logic [255:0] e);
    comparisons++;
    if (g !== e) begin
      n_errors++;
      $display("BAD %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d,
                     output logic [32:0] r);
    int i;
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++) begin
      @(posedge pclk);
      if (pready === 1'b1) break;
    end
    if (i == 20) stuck();
    r = {pslverr, prdata};
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  function automatic logic [255:0] lanes(input logic [15:0] h);
    logic [255:0] m;
    for (int k = 0; k < 16; k++) m[16*k +: 16] = {16{h[k]}};
    return m;
  endfunction : lanes
  function automatic twp_pkg::twp_req_t base(input twp_pkg::twp_mode_t md,
                                             input logic [3:0] sk, input logic [15:0] ex);
    twp_pkg::twp_req_t q;
    q = '0;
    q.mode = md;
    q.fmt = twp_pkg::TWP_FMT_UINT;
    q.chan_skip = sk;
    q.exec = ex;
    for (int i = 0; i < 64; i++) q.texel[32*i +: 32] = 32'(i * 257 + 3);
    return q;
  endfunction : base
  task automatic model(input twp_pkg::twp_req_t q);
    twp_pkg::twp_wb_t w;
    logic s8;
    s8 = q.mode == twp_pkg::TWP_SIMD8_F32;
    for (int c = 0; c < 4; c++) if (!q.chan_skip[c]) begin
      w = '0;
      for (int p = 0; p < 16; p++) begin
        if (!s8) begin
          w.data[16*p +: 16] = q.texel[(c*16+p)*32 +: 16];
          w.hw_en[p] = q.exec[p];
        end else if (p < 8) begin
          w.data[32*p +: 32] = q.texel[(c*16+p)*32 +: 32];
          w.hw_en[2*p +: 2] = {2{q.exec[p]}};
        end
      end
      w.reg_idx = 3'(exp.size());
      exp.push_back(w);
    end
    if (s8 ? q.killpix | q.null_en : q.fault_en | q.null_en) begin
      w = '0;
      w.hw_en = 16'h0003;
      if (!s8) w.data[31:0] = {~q.border, ~q.nullhit};
      else if (q.killpix)
        w.data[31:0] = {24'hffffff, ~q.kill & (q.null_en ? ~q.nullhit[7:0] : 8'hff)};
      else w.data[31:0] = {8'hff, ~q.border[7:0], 8'hff, ~q.nullhit[7:0]};
      w.reg_idx = 3'(exp.size());
      exp.push_back(w);
    end
    if (exp.size() == 0) exp.push_back('0);
    exp[$].last = 1'b1;
  endtask : model
  task automatic run(input twp_pkg::twp_req_t q);
    int i;
    got.delete();
    req <= q;
    req_valid <= 1'b1;
    for (i = 0; i < 50; i++) begin
      @(posedge pclk);
      if (req_ready === 1'b1) break;
    end
    req_valid <= 1'b0;
    if (i == 50) stuck();
    nmsg++;
    for (i = 0; i < 400 && got.size() < exp.size(); i++) @(posedge pclk);
    if (i == 400) stuck();
    repeat (8) @(posedge pclk);
    chk(got.size(), exp.size());
    foreach (exp[k]) if (k < got.size()) begin
      chk(got[k].data & lanes(exp[k].hw_en), exp[k].data & lanes(exp[k].hw_en));
      chk({got[k].hw_en, got[k].reg_idx, got[k].last},
          {exp[k].hw_en, exp[k].reg_idx, exp[k].last});
    end
    exp.delete();
  endtask : run
  task automatic t_regs();
    logic [32:0] r;
    apb(1'b0, 8'h00, 32'h0, r);
    chk(r, 33'h000000001);
    apb(1'b0, 8'h04, 32'h0, r);
    chk(r, 33'h000000000);
    apb(1'b0, 8'h0c, 32'h0, r);
    chk(r, 33'h100000000);
    apb(1'b1, 8'h00, 32'h0, r);
    repeat (3) @(posedge pclk);
    chk(req_ready, 1'b0);
    apb(1'b1, 8'h00, 32'h1, r);
  endtask : t_regs
  task automatic t_all16(input logic [1:0] s);
    twp_pkg::twp_req_t q;
    q = base(twp_pkg::TWP_SIMD16_H16, 4'b0000, 16'hffff);
    q.fault_en = 1'b1;
    q.border = 16'h00f0;
    q.nullhit = 16'h8001;
    speed <= s;
    model(q);
    run(q);
    speed <= 2'h0;
  endtask : t_all16
  task automatic t_skip16();
    twp_pkg::twp_req_t q;
    q = base(twp_pkg::TWP_SIMD16_H16, 4'b0110, 16'h5a3c);
    q.null_en = 1'b1;
    q.nullhit = 16'h0101;
    model(q);
    run(q);
  endtask : t_skip16
  task automatic t_kill8();
    twp_pkg::twp_req_t q;
    q = base(twp_pkg::TWP_SIMD8_F32, 4'b0010, 16'h00a5);
    q.killpix = 1'b1;
    q.kill = 8'h81;
    model(q);
    run(q);
  endtask : t_kill8
  task automatic t_edge();
    twp_pkg::twp_req_t q;
    q = base(twp_pkg::TWP_SIMD8_F32, 4'b1111, 16'h00ff);
    q.null_en = 1'b1;
    q.border = 16'h000f;
    q.nullhit = 16'h0030;
    model(q);
    run(q);
    q = base(twp_pkg::TWP_SIMD16_H16, 4'b1111, 16'hffff);
    model(q);
    run(q);
  endtask : t_edge
  task automatic t_fmt();
    twp_pkg::twp_req_t q;
    q = base(twp_pkg::TWP_SIMD16_H16, 4'b1110, 16'h0001);
    q.texel[95:0] = {32'h00012345, 32'hfffe0000, 32'h3f800000};
    for (int f = 0; f < 3; f++) begin
      q.fmt = twp_pkg::twp_fmt_t'(f);
      q.exec = 16'h0001 << f;
      exp.push_back('{{208'h0, 48'hffff80003c00}, q.exec, 3'h0, 1'b1});
      run(q);
    end
  endtask : t_fmt
  // With the null policy set, channel values of null-hit pixels must come back as zero.
  task automatic t_npol();
    twp_pkg::twp_req_t q;
    logic [32:0] r;
    q = base(twp_pkg::TWP_SIMD16_H16, 4'b1100, 16'hffff);
    q.null_en = 1'b1;
    q.nullhit = 16'h0081;
    apb(1'b1, 8'h00, 32'h3, r);
    apb(1'b0, 8'h00, 32'h0, r);
    chk(r, 33'h000000003);
    model(q);
    exp[0].data &= ~lanes(q.nullhit);
    exp[1].data &= ~lanes(q.nullhit);
    run(q);
    apb(1'b1, 8'h00, 32'h1, r);
  endtask : t_npol
  initial begin
    logic [32:0] r;
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    repeat (2) @(posedge pclk);
    t_regs();
    t_all16(2'h0);
    t_all16(2'h1);
    t_skip16();
    t_kill8();
    t_edge();
    t_fmt();
    t_npol();
    apb(1'b0, 8'h08, 32'h0, r);
    chk(r, 33'(nmsg));
    wrap_up();
  end
endmodule : texture_result_writeback_packer_test
